// ==== design/dp_slave_telegram_handler.sv ====
`timescale 1ns/100ps
`include "dp_slave_consts.svh"

// How it works
// - ChkCfg answered by short acknowledgement outside wait-parameters
// - I/O bytes follow configured module order
// - SlaveDiag returns status, ident, app diagnostics
// - One DataExchange carries all outputs and inputs
// - New diagnostics raise flag in DataExchange answer
// - GlobalControl broadcast acted on outside wait-parameters, no reply
// - Sync mode reported in diagnostic status byte
// - Sync mode holds outputs; each Sync applies latest
// - Freeze latches inputs for DataExchange
// - DPV1 class 1 allowed from wait-configuration
// - DPV1 class 2 link independent of cyclic state
// - Address is tens switch times ten plus units
// - Delivered switches give address eleven
// - Switch changes act only after reset
// - Divider covers 9.6 kbit/s to 12 Mbit/s
// - Bad parameters flagged, back to wait-parameters
// - Transmit only as answer to a request
module dp_slave_telegram_handler
    import dp_slave_pkg::*;
#(
    parameter logic [15:0] IDENT_NUMBER = 16'h5A3C, // Arbitrary value
    parameter logic [15:0] DIV_9K6 = 16'(`BAUD_DIV(`RATE_9K6)),
    parameter logic [15:0] DIV_19K2 = 16'(`BAUD_DIV(`RATE_19K2))
) (
    input wire logic I_CLOCK,
    input wire logic I_SRST,
    input wire beat_t I_RX,
    output beat_t O_TX,
    input wire image_t I_INPUTS,
    output image_t O_OUTPUTS,
    input wire logic [7:0] I_APP_DIAG,
    input wire logic I_DIAG_EVENT,
    input wire logic [3:0] I_ADDR_TENS_SW,
    input wire logic [3:0] I_ADDR_UNITS_SW,
    output logic [6:0] O_STATION_ADDR,
    input wire logic [3:0] I_BAUD_SEL,
    output logic O_BIT_TICK,
    output logic O_DATA_EXCH,
    output logic O_SYNC_MODE,
    output logic O_FREEZE_MODE
);

    dp_state_t st_q, st_d; // Startup state
    logic [7:0] svc_q, svc_d; // Service of open telegram
    logic in_frame_q, in_frame_d; // Past first byte of a telegram
    logic [3:0] cnt_q, cnt_d; // Payload bytes received
    logic ovf_q, ovf_d; // Payload longer than buffer
    logic [7:0][7:0] buf_q, buf_d; // Payload bytes
    logic [3:0][1:0] in_ch_q, in_ch_d; // Input channel per response slot
    logic [3:0][1:0] out_ch_q, out_ch_d; // Output channel per request slot
    logic prm_fault_q, prm_fault_d;
    logic cfg_fault_q, cfg_fault_d;
    logic diag_pend_q, diag_pend_d; // Diagnostics not yet fetched
    logic sync_q, sync_d;
    logic freeze_q, freeze_d;
    logic c2_open_q, c2_open_d; // Class 2 connection established
    image_t out_buf_q, out_buf_d; // Outputs not yet applied
    image_t out_q, out_d; // Physical outputs
    image_t frz_q, frz_d; // Frozen inputs
    image_t snap_q, snap_d; // Inputs for the answer
    logic [7:0][7:0] dset_q, dset_d; // Acyclic data set
    resp_t kind_q, kind_d;
    logic [7:0] rd_q, rd_d; // Byte returned by an acyclic read
    logic [2:0] tx_idx_q, tx_idx_d;
    logic tx_busy_q, tx_busy_d;
    beat_t tx_q, tx_d;
    logic [6:0] addr_q, addr_d;
    logic addr_taken_q, addr_taken_d;
    logic [15:0] div_cnt_q, div_cnt_d;
    logic tick_q, tick_d;

    // Next state
    always_comb begin
        logic done;
        logic [2:0] ni;
        logic [2:0] no;
        logic [2:0] len;
        logic [7:0] status;
        logic [15:0] div;
        done = 1'b0;
        ni = 3'h0;
        no = 3'h0;
        len = 3'h1;
        div = 16'h0001;
        st_d = st_q;
        svc_d = svc_q;
        in_frame_d = in_frame_q;
        cnt_d = cnt_q;
        ovf_d = ovf_q;
        buf_d = buf_q;
        in_ch_d = in_ch_q;
        out_ch_d = out_ch_q;
        prm_fault_d = prm_fault_q;
        cfg_fault_d = cfg_fault_q;
        diag_pend_d = diag_pend_q;
        sync_d = sync_q;
        freeze_d = freeze_q;
        c2_open_d = c2_open_q;
        out_buf_d = out_buf_q;
        out_d = out_q;
        frz_d = frz_q;
        snap_d = snap_q;
        dset_d = dset_q;
        kind_d = kind_q;
        rd_d = rd_q;
        tx_idx_d = tx_idx_q;
        tx_busy_d = tx_busy_q;
        tx_d = '0;
        addr_d = addr_q;
        addr_taken_d = addr_taken_q;
        status = 8'h00;
        status[`DIAG_PRM_FAULT_BIT] = prm_fault_q;
        status[`DIAG_CFG_FAULT_BIT] = cfg_fault_q;
        status[`DIAG_NOT_READY_BIT] = (st_q != DATA_EXCH);
        status[`DIAG_SYNC_BIT] = sync_q;
        status[`DIAG_FREEZE_BIT] = freeze_q;

        // Bytes during an answer are dropped; master waits
        if (I_RX.valid && !tx_busy_q) begin
            if (!in_frame_q) begin
                svc_d = I_RX.data;
                cnt_d = 4'h0;
                ovf_d = 1'b0;
            end else if (cnt_q < 4'(`PAYLOAD_MAX)) begin
                buf_d[cnt_q[2:0]] = I_RX.data;
                cnt_d = cnt_q + 4'h1;
            end else begin
                ovf_d = 1'b1;
            end
            in_frame_d = !I_RX.last;
            done = I_RX.last;
        end

        // Whole telegram in: decode
        if (done) begin
            kind_d = RESP_NAK;
            tx_busy_d = 1'b1;
            tx_idx_d = 3'h0;
            if (ovf_d) begin
                kind_d = RESP_NAK;
            end else begin
                case (svc_d)
                    `SVC_SET_PRM: begin
                        kind_d = RESP_ACK;
                        sync_d = 1'b0;
                        freeze_d = 1'b0;
                        if (cnt_d == 4'(`PRM_LEN) && {buf_d[0], buf_d[1]} == IDENT_NUMBER) begin
                            prm_fault_d = 1'b0;
                            st_d = WAIT_CFG;
                        end else begin
                            prm_fault_d = 1'b1;
                            st_d = WAIT_PRM;
                        end
                    end
                    `SVC_CHK_CFG: begin
                        if (st_q != WAIT_PRM) begin
                            kind_d = RESP_ACK;
                            for (int i = 0; i < `PAYLOAD_MAX; i++) begin
                                if (buf_d[i][`CFG_DIR_BIT]) begin
                                    if (no < 3'(`IO_BYTES)) begin
                                        out_ch_d[no[1:0]] = buf_d[i][`CFG_CH_MSB:0];
                                    end
                                    no = no + 3'h1;
                                end else begin
                                    if (ni < 3'(`IO_BYTES)) begin
                                        in_ch_d[ni[1:0]] = buf_d[i][`CFG_CH_MSB:0];
                                    end
                                    ni = ni + 3'h1;
                                end
                            end
                            if (cnt_d == 4'(`PAYLOAD_MAX) && ni == 3'(`IO_BYTES)
                                && no == 3'(`IO_BYTES)) begin
                                cfg_fault_d = 1'b0;
                                st_d = DATA_EXCH;
                            end else begin
                                cfg_fault_d = 1'b1;
                                st_d = WAIT_CFG;
                            end
                        end
                    end
                    `SVC_SLAVE_DIAG: begin
                        if (cnt_d == 4'h0) begin
                            kind_d = RESP_DIAG;
                            diag_pend_d = 1'b0;
                        end
                    end
                    `SVC_DATA_EXCH: begin
                        if (st_q == DATA_EXCH && cnt_d == 4'(`IO_BYTES)) begin
                            kind_d = RESP_DX;
                            for (int j = 0; j < `IO_BYTES; j++) begin
                                out_buf_d[out_ch_q[j]] = buf_d[j];
                            end
                            if (!sync_q) begin
                                out_d = out_buf_d;
                            end
                            snap_d = freeze_q ? frz_q : I_INPUTS;
                        end
                    end
                    `SVC_GLOBAL_CTRL: begin
                        tx_busy_d = 1'b0;
                        if (cnt_d == 4'h1 && st_q != WAIT_PRM) begin
                            if (buf_d[0][`GC_SYNC_BIT]) begin
                                sync_d = 1'b1;
                                out_d = out_buf_d;
                                diag_pend_d = diag_pend_q | !sync_q;
                            end else if (buf_d[0][`GC_UNSYNC_BIT]) begin
                                sync_d = 1'b0;
                                out_d = out_buf_d;
                            end
                            if (buf_d[0][`GC_FREEZE_BIT]) begin
                                freeze_d = 1'b1;
                                frz_d = I_INPUTS;
                            end else if (buf_d[0][`GC_UNFREEZE_BIT]) begin
                                freeze_d = 1'b0;
                            end
                        end
                    end
                    `SVC_C1_READ: begin
                        if (st_q != WAIT_PRM && cnt_d == 4'h1) begin
                            kind_d = RESP_READ;
                            rd_d = dset_q[buf_d[0][2:0]];
                        end
                    end
                    `SVC_C1_WRITE: begin
                        if (st_q != WAIT_PRM && cnt_d == 4'h2) begin
                            kind_d = RESP_ACK;
                            dset_d[buf_d[0][2:0]] = buf_d[1];
                        end
                    end
                    `SVC_C2_INIT: begin
                        kind_d = RESP_ACK;
                        c2_open_d = 1'b1;
                    end
                    `SVC_C2_ABORT: begin
                        kind_d = RESP_ACK;
                        c2_open_d = 1'b0;
                    end
                    `SVC_C2_READ: begin
                        if (c2_open_q && cnt_d == 4'h1) begin
                            kind_d = RESP_READ;
                            rd_d = dset_q[buf_d[0][2:0]];
                        end
                    end
                    `SVC_C2_WRITE: begin
                        if (c2_open_q && cnt_d == 4'h2) begin
                            kind_d = RESP_ACK;
                            dset_d[buf_d[0][2:0]] = buf_d[1];
                        end
                    end
                    default: begin
                        kind_d = RESP_NAK;
                    end
                endcase
            end
        end

        // Answer bytes, one a cycle
        if (tx_busy_q) begin
            case (kind_q)
                RESP_DIAG: len = 3'(`DIAG_LEN);
                RESP_DX: len = 3'(`DX_RESP_LEN);
                default: len = 3'h1;
            endcase
            tx_d.valid = 1'b1;
            tx_d.last = (tx_idx_q == len - 3'h1);
            case (kind_q)
                RESP_ACK: tx_d.data = `SHORT_ACK;
                RESP_READ: tx_d.data = rd_q;
                RESP_DIAG: begin
                    case (tx_idx_q)
                        3'h0: tx_d.data = status;
                        3'h1: tx_d.data = IDENT_NUMBER[15:8];
                        3'h2: tx_d.data = IDENT_NUMBER[7:0];
                        3'h3: tx_d.data = {1'b0, addr_q};
                        default: tx_d.data = I_APP_DIAG;
                    endcase
                end
                RESP_DX: begin
                    if (tx_idx_q == 3'h0) begin
                        tx_d.data = 8'h00;
                        tx_d.data[`DX_DIAG_FLAG_BIT] = diag_pend_q;
                    end else begin
                        tx_d.data = snap_q[in_ch_q[tx_idx_q[1:0] - 2'h1]];
                    end
                end
                default: tx_d.data = `NEG_ACK;
            endcase
            tx_idx_d = tx_idx_q + 3'h1;
            tx_busy_d = !tx_d.last;
        end

        // Event after the clear so it wins
        if (I_DIAG_EVENT) begin
            diag_pend_d = 1'b1;
        end

        // Switches read once after reset
        if (!addr_taken_q) begin
            addr_d = 7'({3'h0, I_ADDR_TENS_SW} * 7'h0A) + {3'h0, I_ADDR_UNITS_SW};
            addr_taken_d = 1'b1;
        end

        // Bit clock enable; new rate at next reload
        case (I_BAUD_SEL)
            4'h0: div = DIV_9K6;
            4'h1: div = DIV_19K2;
            4'h2: div = 16'(`BAUD_DIV(`RATE_93K75));
            4'h3: div = 16'(`BAUD_DIV(`RATE_187K5));
            4'h4: div = 16'(`BAUD_DIV(`RATE_500K));
            4'h5: div = 16'(`BAUD_DIV(`RATE_1M5));
            4'h6: div = 16'(`BAUD_DIV(`RATE_3M));
            4'h7: div = 16'(`BAUD_DIV(`RATE_6M));
            default: div = 16'(`BAUD_DIV(`RATE_12M));
        endcase
        tick_d = (div_cnt_q == 16'h0000);
        div_cnt_d = tick_d ? div - 16'h0001 : div_cnt_q - 16'h0001;
    end

    // Registers only
    always_ff @(posedge I_CLOCK) begin
        if (I_SRST) begin
            st_q <= WAIT_PRM;
            svc_q <= 8'h00;
            in_frame_q <= 1'b0;
            cnt_q <= 4'h0;
            ovf_q <= 1'b0;
            buf_q <= '0;
            in_ch_q <= '0;
            out_ch_q <= '0;
            prm_fault_q <= 1'b0;
            cfg_fault_q <= 1'b0;
            diag_pend_q <= 1'b0;
            sync_q <= 1'b0;
            freeze_q <= 1'b0;
            c2_open_q <= 1'b0;
            out_buf_q <= '0;
            out_q <= '0;
            frz_q <= '0;
            snap_q <= '0;
            dset_q <= '0;
            kind_q <= RESP_NAK;
            rd_q <= `RESP_BYTE_RESET;
            tx_idx_q <= 3'h0;
            tx_busy_q <= 1'b0;
            tx_q <= '0;
            addr_q <= `ADDR_RESET;
            addr_taken_q <= 1'b0;
            div_cnt_q <= 16'h0000;
            tick_q <= 1'b0;
        end else begin
            st_q <= st_d;
            svc_q <= svc_d;
            in_frame_q <= in_frame_d;
            cnt_q <= cnt_d;
            ovf_q <= ovf_d;
            buf_q <= buf_d;
            in_ch_q <= in_ch_d;
            out_ch_q <= out_ch_d;
            prm_fault_q <= prm_fault_d;
            cfg_fault_q <= cfg_fault_d;
            diag_pend_q <= diag_pend_d;
            sync_q <= sync_d;
            freeze_q <= freeze_d;
            c2_open_q <= c2_open_d;
            out_buf_q <= out_buf_d;
            out_q <= out_d;
            frz_q <= frz_d;
            snap_q <= snap_d;
            dset_q <= dset_d;
            kind_q <= kind_d;
            rd_q <= rd_d;
            tx_idx_q <= tx_idx_d;
            tx_busy_q <= tx_busy_d;
            tx_q <= tx_d;
            addr_q <= addr_d;
            addr_taken_q <= addr_taken_d;
            div_cnt_q <= div_cnt_d;
            tick_q <= tick_d;
        end
    end

    // Outputs from flip-flops except O_DATA_EXCH, a decode of st_q
    assign O_TX = tx_q;
    assign O_OUTPUTS = out_q;
    assign O_STATION_ADDR = addr_q;
    assign O_BIT_TICK = tick_q;
    assign O_DATA_EXCH = (st_q == DATA_EXCH);
    assign O_SYNC_MODE = sync_q;
    assign O_FREEZE_MODE = freeze_q;

endmodule

// ==== design/dp_slave_consts.svh ====
`ifndef DP_SLAVE_CONSTS_SVH
`define DP_SLAVE_CONSTS_SVH

// Service code, first byte of a request
`define SVC_SET_PRM 8'h01
`define SVC_CHK_CFG 8'h02
`define SVC_SLAVE_DIAG 8'h03
`define SVC_DATA_EXCH 8'h04
`define SVC_GLOBAL_CTRL 8'h05
`define SVC_C1_READ 8'h10
`define SVC_C1_WRITE 8'h11
`define SVC_C2_INIT 8'h20
`define SVC_C2_ABORT 8'h21
`define SVC_C2_READ 8'h22
`define SVC_C2_WRITE 8'h23

// Answer bytes
`define SHORT_ACK 8'hE5
`define NEG_ACK 8'hFE

// GlobalControl byte fields
`define GC_SYNC_BIT 0
`define GC_UNSYNC_BIT 1
`define GC_FREEZE_BIT 2
`define GC_UNFREEZE_BIT 3

// Configuration byte fields
`define CFG_DIR_BIT 7
`define CFG_CH_MSB 1

// Diagnostic byte fields
`define DIAG_PRM_FAULT_BIT 0
`define DIAG_CFG_FAULT_BIT 1
`define DIAG_NOT_READY_BIT 2
`define DIAG_SYNC_BIT 3
`define DIAG_FREEZE_BIT 4
`define DX_DIAG_FLAG_BIT 0

// Telegram sizes in bytes
`define IO_BYTES 4
`define PAYLOAD_MAX 8
`define PRM_LEN 2
`define DIAG_LEN 5
`define DX_RESP_LEN 5

// Reset values
`define ADDR_RESET 7'h0B
`define RESP_BYTE_RESET 8'h00

// Clock and bit rates in Hz
`define CLK_HZ 250000000
`define RATE_9K6 9600
`define RATE_19K2 19200
`define RATE_93K75 93750
`define RATE_187K5 187500
`define RATE_500K 500000
`define RATE_1M5 1500000
`define RATE_3M 3000000
`define RATE_6M 6000000
`define RATE_12M 12000000
`define BAUD_DIV(r) ((`CLK_HZ + (r) / 2) / (r))

`endif

// ==== design/dp_slave_pkg.sv ====
package dp_slave_pkg;
    // Slave startup and exchange states
    typedef enum logic [1:0] {WAIT_PRM, WAIT_CFG, DATA_EXCH} dp_state_t;
    // Kind of answer being sent
    typedef enum logic [2:0] {RESP_ACK, RESP_NAK, RESP_DIAG, RESP_DX, RESP_READ} resp_t;
    // One byte of a telegram on the link side
    typedef struct packed {
        logic valid;
        logic last;
        logic [7:0] data;
    } beat_t;
    // Process image of four bytes
    typedef logic [3:0][7:0] image_t;
endpackage

// ==== testbench/dp_slave_handler_sva.sv ====
`timescale 1ns/100ps
`include "dp_slave_consts.svh"
// Port checks of the handler
module dp_slave_handler_sva
    import dp_slave_pkg::*;
(
    input wire logic I_CLOCK,
    input wire logic I_SRST,
    input wire beat_t I_RX,
    input wire beat_t O_TX,
    input wire image_t O_OUTPUTS,
    input wire logic [3:0] I_ADDR_TENS_SW,
    input wire logic [3:0] I_ADDR_UNITS_SW,
    input wire logic [6:0] O_STATION_ADDR,
    input wire logic O_BIT_TICK,
    input wire logic O_SYNC_MODE,
    input wire logic O_FREEZE_MODE
);
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (I_SRST);
    logic first_q, first_d; // Next byte opens a telegram
    logic [7:0] code_q, code_d; // Code of the open telegram
    logic [7:0] code_now; // Code of the present byte
    logic end_now; // Closing byte now
    logic gc_end; // Broadcast closing byte
    assign code_now = first_q ? I_RX.data : code_q;
    assign end_now = I_RX.valid && I_RX.last;
    assign gc_end = end_now && code_now == `SVC_GLOBAL_CTRL;
    // Framing follower; dropped bytes not modelled
    always_comb begin
        first_d = first_q;
        code_d = code_q;
        if (I_RX.valid) begin
            first_d = I_RX.last;
            code_d = code_now;
        end
    end
    // Framing registers
    always_ff @(posedge I_CLOCK) begin
        if (I_SRST) begin
            first_q <= 1'b1;
            code_q <= 8'h00;
        end else begin
            first_q <= first_d;
            code_q <= code_d;
        end
    end
    sequence s_one_byte;
        ##2 O_TX.valid && O_TX.last && (O_TX.data == `SHORT_ACK || O_TX.data == `NEG_ACK);
    endsequence
    sequence s_silent;
        ##1 (!O_TX.valid) [*4];
    endsequence
    a_cfg_short_ack: assert property (
        end_now && code_now == `SVC_CHK_CFG |-> s_one_byte)
        else $error("ChkCfg answer not one byte");
    a_gc_no_reply: assert property (gc_end |-> s_silent)
        else $error("Broadcast answered");
    a_reply_follows: assert property ($rose(O_TX.valid) |-> $past(end_now, 2))
        else $error("Unrequested answer");
    a_reply_unbroken: assert property (
        O_TX.valid && !O_TX.last |=> O_TX.valid)
        else $error("Answer bytes gapped");
    a_out_on_request: assert property (
        $changed(O_OUTPUTS) && !$past(I_SRST) |-> $past(end_now))
        else $error("Outputs moved unasked");
    a_sync_holds_out: assert property (
        O_SYNC_MODE && $changed(O_OUTPUTS) && !$past(I_SRST) |->
            $past(gc_end && I_RX.data[`GC_SYNC_BIT]))
        else $error("Outputs moved in sync mode");
    a_sync_from_gc: assert property (
        $rose(O_SYNC_MODE) |-> $past(gc_end && I_RX.data[`GC_SYNC_BIT]))
        else $error("Sync mode unasked");
    a_freeze_from_gc: assert property (
        $rose(O_FREEZE_MODE) |-> $past(gc_end && I_RX.data[`GC_FREEZE_BIT]))
        else $error("Freeze mode unasked");
    a_addr_decode: assert property (
        $fell(I_SRST) |-> ##2 O_STATION_ADDR == 7'($past(I_ADDR_TENS_SW, 2)) * 7'h0A
            + 7'($past(I_ADDR_UNITS_SW, 2)))
        else $error("Bad station address");
    a_addr_frozen: assert property ((!I_SRST) [*3] |=> $stable(O_STATION_ADDR))
        else $error("Station address moved");
    a_tick_spacing: assert property (O_BIT_TICK |=> (!O_BIT_TICK) [*7])
        else $error("Bit ticks too close");
endmodule

bind dp_slave_telegram_handler dp_slave_handler_sva dp_slave_handler_sva_i (
    .I_CLOCK, .I_SRST, .I_RX, .O_TX, .O_OUTPUTS, .I_ADDR_TENS_SW, .I_ADDR_UNITS_SW,
    .O_STATION_ADDR, .O_BIT_TICK, .O_SYNC_MODE, .O_FREEZE_MODE);

// ==== testbench/dp_master_model.sv ====
`timescale 1ns/100ps
// Master stand-in: telegram out, answer back
module dp_master_model
    import dp_slave_pkg::*;
(
    input wire logic i_clock,
    input wire beat_t i_tx,
    output beat_t o_rx
);
    // Line starts idle
    initial o_rx = '0;

    // Answer bytes up to the closing byte, bounded wait
    task automatic request(input logic [7:0] req[$], input int n,
                           output logic [7:0] ans[$], output bit ok);
        int i;
        ans = {};
        ok = (n == 0);
        // Request bytes back to back
        for (i = 0; i < req.size(); i++) begin
            @(negedge i_clock);
            o_rx <= {1'b1, i == req.size() - 1, req[i]};
        end
        @(negedge i_clock);
        // Idle line shows inverted data; no stale byte
        o_rx <= {2'b00, ~req[req.size() - 1]};
        // Silent requests watched four cycles
        for (i = 0; i < 12 && !(n == 0 && i == 4); i++) begin
            @(negedge i_clock);
            if (i_tx.valid) begin
                ans.push_back(i_tx.data);
                ok = i_tx.last;
            end
            if (ok && n > 0)
                break;
        end
    endtask
endmodule

// ==== testbench/tb_top.sv ====
`timescale 1ns/100ps
`include "dp_slave_consts.svh"
// Self-checking bench with an integer model
module tb_top
    import dp_slave_pkg::*;
;
    localparam logic [15:0] ID = 16'hC3A5; // Arbitrary ident value
    logic clk = 1'b0;
    logic srst = 1'b1;
    beat_t rx;
    beat_t tx;
    image_t inputs = '0;
    image_t outputs;
    logic [7:0] app_diag = 8'h00;
    logic diag_ev = 1'b0;
    logic [3:0] tens = 4'h1;
    logic [3:0] units = 4'h1;
    logic [3:0] baud = 4'h0;
    logic [6:0] addr;
    logic tick, dx, syncm, frzm;
    int n_errors = 0;
    int checked = 0;
    int out_ch[4], in_ch[4]; // Configured channel of each slot
    int pend, sync_on, frz_on; // Model flags
    image_t held, applied, frozen; // Model output buffer and images
    logic [6:0] addr_exp;
    logic [7:0] ans[$];
    int div_exp[10] = '{8, 12, 2667, 1333, 500, 167, 83, 42, 21, 21};

    // Fast test dividers
    dp_slave_telegram_handler #(.IDENT_NUMBER(ID), .DIV_9K6(16'h0008), .DIV_19K2(16'h000C))
        dp_slave_telegram_handler_i (
        .I_CLOCK(clk), .I_SRST(srst), .I_RX(rx), .O_TX(tx), .I_INPUTS(inputs),
        .O_OUTPUTS(outputs), .I_APP_DIAG(app_diag), .I_DIAG_EVENT(diag_ev),
        .I_ADDR_TENS_SW(tens), .I_ADDR_UNITS_SW(units), .O_STATION_ADDR(addr),
        .I_BAUD_SEL(baud), .O_BIT_TICK(tick), .O_DATA_EXCH(dx), .O_SYNC_MODE(syncm),
        .O_FREEZE_MODE(frzm));
    dp_master_model dp_master_model_i (.i_clock(clk), .i_tx(tx), .o_rx(rx));

    // 250 MHz clock
    initial forever #2 clk = ~clk;

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        if (n_errors == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Missing answer ends the run
    task automatic xfer(input logic [7:0] req[$], input int n);
        bit ok;
        dp_master_model_i.request(req, n, ans, ok);
        check("length", ans.size(), n);
        if (!ok) begin
            n_errors++;
            test_done();
        end
    endtask

    task automatic one(input logic [7:0] req[$], input logic [7:0] exp);
        xfer(req, 1);
        check("answer", ans[0], exp);
    endtask

    task automatic diag(input logic [7:0] status);
        @(negedge clk);
        app_diag = 8'($urandom);
        xfer({`SVC_SLAVE_DIAG}, 5);
        check("status", ans[0], status);
        check("ident", {ans[1], ans[2]}, ID);
        check("diag addr", ans[3], {1'b0, addr_exp});
        check("app diag", ans[4], app_diag);
        pend = 0;
    endtask

    // Clear sends zero failsafe outputs
    task automatic dx_cycle(input bit clear);
        logic [7:0] req[$];
        image_t src;
        int j;
        req = {`SVC_DATA_EXCH};
        @(negedge clk);
        inputs = image_t'($urandom);
        src = frz_on ? frozen : inputs;
        for (j = 0; j < 4; j++) begin
            req.push_back(clear ? 8'h00 : 8'($urandom));
            held[out_ch[j]] = req[j + 1];
        end
        if (!sync_on)
            applied = held;
        xfer(req, 5);
        check("dx flag", ans[0][0], pend[0]);
        for (j = 0; j < 4; j++)
            check("input", ans[j + 1], src[in_ch[j]]);
        check("outputs", outputs, applied);
    endtask

    task automatic gc(input logic [7:0] cmd);
        xfer({`SVC_GLOBAL_CTRL, cmd}, 0);
        if (cmd[0]) begin
            sync_on = 1;
            applied = held;
        end else if (cmd[1])
            sync_on = 0;
        if (cmd[2]) begin
            frz_on = 1;
            frozen = inputs;
        end else if (cmd[3])
            frz_on = 0;
        check("sync", syncm, sync_on[0]);
        check("freeze", frzm, frz_on[0]);
        check("outputs", outputs, applied);
    endtask

    // Address ignores later switch moves
    task automatic do_reset(input logic [3:0] t, input logic [3:0] u);
        @(negedge clk);
        srst = 1'b1;
        tens = t;
        units = u;
        repeat (4) @(negedge clk);
        srst = 1'b0;
        addr_exp = 7'(t) * 7'h0A + 7'(u);
        repeat (3) @(negedge clk);
        tens = 4'h9 - t;
        units = 4'h9 - u;
        repeat (3) @(negedge clk);
        check("address", addr, addr_exp);
        check("reset outputs", outputs, '0);
        {pend, sync_on, frz_on} = '0;
        {held, applied} = '0;
    endtask

    task automatic wait_tick(output int n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (!tick && n < 4000);
        if (!tick) begin
            n_errors++;
            test_done();
        end
    endtask

    initial begin
        logic [7:0] cfg[$];
        logic [7:0] v;
        int i, j, n;
        void'($urandom(37));
        do_reset(4'h1, 4'h1);
        v = 8'($urandom);
        one({`SVC_C1_READ, 8'h03}, `NEG_ACK);
        one({`SVC_C2_READ, 8'h05}, `NEG_ACK);
        one({`SVC_C2_INIT}, `SHORT_ACK);
        one({`SVC_C2_WRITE, 8'h05, v}, `SHORT_ACK);
        one({`SVC_C2_READ, 8'h05}, v);
        one({`SVC_C2_ABORT}, `SHORT_ACK);
        one({`SVC_C2_READ, 8'h05}, `NEG_ACK);
        one({`SVC_CHK_CFG}, `NEG_ACK);
        one({8'h77}, `NEG_ACK);
        one({`SVC_SET_PRM, ~ID[15:8], ID[7:0]}, `SHORT_ACK);
        diag(8'h05);
        one({`SVC_SET_PRM, ID[15:8], ID[7:0]}, `SHORT_ACK);
        diag(8'h04);
        one({`SVC_C1_WRITE, 8'h02, ~v}, `SHORT_ACK);
        one({`SVC_C1_READ, 8'h02}, ~v);
        // Random slot order, in and out interleaved
        out_ch = '{0, 1, 2, 3};
        in_ch = '{3, 2, 1, 0};
        for (i = 3; i > 0; i--) begin
            j = $urandom_range(i);
            {out_ch[i], out_ch[j]} = {out_ch[j], out_ch[i]};
            j = $urandom_range(i);
            {in_ch[i], in_ch[j]} = {in_ch[j], in_ch[i]};
        end
        cfg = {`SVC_CHK_CFG};
        for (i = 0; i < 4; i++) begin
            cfg.push_back(8'h80 | 8'(out_ch[i]));
            cfg.push_back(8'(in_ch[i]));
        end
        one(cfg, `SHORT_ACK);
        for (i = 0; i < 8 && !dx; i++)
            xfer({`SVC_SLAVE_DIAG}, 5);
        check("dx", dx, 1'b1);
        diag(8'h00);
        dx_cycle(1'b1);
        dx_cycle(1'b0);
        @(negedge clk);
        diag_ev = 1'b1;
        @(negedge clk);
        diag_ev = 1'b0;
        pend = 1;
        dx_cycle(1'b0);
        diag(8'h00);
        dx_cycle(1'b0);
        gc(8'h01);
        diag(8'h08);
        dx_cycle(1'b0);
        gc(8'h01);
        gc(8'h02);
        diag(8'h00);
        gc(8'h04);
        dx_cycle(1'b0);
        gc(8'h08);
        dx_cycle(1'b0);
        // Divider for every rate
        for (i = 0; i < 10; i++) begin
            @(negedge clk);
            baud = (i == 9) ? 4'hF : 4'(i);
            repeat (3) wait_tick(n);
            check("tick period", n, div_exp[i]);
        end
        do_reset(4'($urandom_range(9)), 4'($urandom_range(9)));
        test_done();
    end
endmodule
